// ==== verilog/ewbs_top.sv ====
// Overview of operation
// [R1] Array operations refused during internal write
// [R2] Chip select low after write command starts write
// [R3] Host may instead wait 10 ms
// [R4] Selected while writing: data output driven low
// [R5] Selected after write done: data output high
// [R6] Host polls by pulsing or holding select
// [R7] Status needs no serial clock edges
// [R8] Ready stays shown until a start bit
// [R9] Start bit while selected clears ready
// [R10] Partial command dropped when select falls
// [R11] Deselected: data output released, not driven
`timescale 1ns/1ns
`include "ewbs_defs.svh"

module ewbs_top #(
	parameter int WRITE_CYC = `EWBS_WRITE_CYC
) (
	input  wire logic                    clk_sys,
	input  wire logic                    sys_rst,
	input  wire logic                    chip_sel,
	input  wire logic                    serial_clock,
	input  wire logic                    serial_data_in,
	output logic                         dout_q,
	output logic                         dout_oe_q,
	output logic                         busy_q,
	output logic                         nv_wr_stb_q,
	output logic [`EWBS_ADDR_W-1:0]      nv_wr_addr_q,
	output logic [`EWBS_DATA_W-1:0]      nv_wr_data_q
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	ewbs_pkg::ewbs_pins_s pins_raw;
	ewbs_pkg::ewbs_pins_s pins_s;

	assign pins_raw = '{chip_sel: chip_sel, serial_clock: serial_clock,
		serial_data_in: serial_data_in};

	ewbs_sync #(
		.W        ($bits(ewbs_pkg::ewbs_pins_s))
	) u_sync (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.async_in (pins_raw),
		.sync_out (pins_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// State and decode

	ewbs_pkg::ewbs_state_e   state_q;
	ewbs_pkg::ewbs_state_e   state_d;
	ewbs_pkg::ewbs_cmd_s     cmd_q;
	ewbs_pkg::ewbs_cmd_s     cmd_d;
	logic [`EWBS_BCNT_W-1:0] bcnt_q;
	logic [`EWBS_BCNT_W-1:0] bcnt_d;
	logic [`EWBS_WCNT_W-1:0] wcnt_q;
	logic [`EWBS_WCNT_W-1:0] wcnt_d;
	logic                    sk_prev_q;
	logic                    rdy_q;
	logic                    rdy_d;
	logic                    cs_s;
	logic                    di_s;
	logic                    sk_rise;
	logic                    start_bit;
	logic                    last_bit;
	logic                    is_write;
	logic                    in_busy;
	logic                    wr_done;
	logic                    arm_go;

	// Serial clock edge and frame decode
	assign cs_s      = pins_s.chip_sel;
	assign di_s      = pins_s.serial_data_in;
	assign sk_rise   = pins_s.serial_clock & ~sk_prev_q;
	assign in_busy   = (state_q == ewbs_pkg::EWBS_BUSY);
	assign start_bit = (state_q == ewbs_pkg::EWBS_IDLE) & cs_s & sk_rise & di_s; // [R9]
	assign last_bit  = (bcnt_q == `EWBS_BCNT_W'(`EWBS_CMD_BITS - 1));
	assign cmd_d     = ewbs_pkg::ewbs_cmd_s'({cmd_q[`EWBS_CMD_BITS-2:0], di_s});
	assign is_write  = (cmd_d.op == `EWBS_OP_WRITE);
	assign wr_done   = in_busy & (wcnt_q == `EWBS_WCNT_W'(WRITE_CYC - 1));
	assign arm_go    = (state_q == ewbs_pkg::EWBS_ARMED) & ~cs_s; // [R2]

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	// Busy ignores the clock and data pins until the timer expires; select still gates the status output
	always_comb begin
		state_d = state_q;
		bcnt_d  = bcnt_q;
		wcnt_d  = wcnt_q;
		unique case (state_q)
			ewbs_pkg::EWBS_IDLE: begin
				bcnt_d = '0;
				if (start_bit) begin
					state_d = ewbs_pkg::EWBS_SHIFT;
				end
			end
			ewbs_pkg::EWBS_SHIFT: begin
				if (!cs_s) begin
					state_d = ewbs_pkg::EWBS_IDLE; // [R10]
				end else if (sk_rise) begin
					bcnt_d = bcnt_q + `EWBS_BCNT_W'(1);
					if (last_bit) begin
						state_d = is_write ? ewbs_pkg::EWBS_ARMED
							: ewbs_pkg::EWBS_IDLE;
					end
				end
			end
			ewbs_pkg::EWBS_ARMED: begin
				wcnt_d = '0;
				if (arm_go) begin
					state_d = ewbs_pkg::EWBS_BUSY; // [R2]
				end
			end
			ewbs_pkg::EWBS_BUSY: begin
				wcnt_d = wcnt_q + `EWBS_WCNT_W'(1);
				if (wr_done) begin
					state_d = ewbs_pkg::EWBS_IDLE; // [R1]
				end
			end
		endcase
	end

	// Completion sets ready, a start bit clears it; set wins
	assign rdy_d = wr_done | (rdy_q & ~start_bit); // [R8] [R9]

	////////////////////////////////////////////////////////////////////////////
	// Registers

	// Control state
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_q   <= ewbs_pkg::EWBS_IDLE;
			bcnt_q    <= '0;
			wcnt_q    <= '0;
			sk_prev_q <= 1'h0;
			rdy_q     <= 1'h0;
		end else begin
			state_q   <= state_d;
			bcnt_q    <= bcnt_d;
			wcnt_q    <= wcnt_d;
			sk_prev_q <= pins_s.serial_clock;
			rdy_q     <= rdy_d;
		end
	end

	// Command shifter, only while a frame is open
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cmd_q <= '0;
		end else if (state_q == ewbs_pkg::EWBS_SHIFT && cs_s && sk_rise) begin
			cmd_q <= cmd_d;
		end
	end

	// Status on the data output depends on select level and busy/ready state, not on serial clock edges
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			dout_q    <= `EWBS_ST_BUSY;
			dout_oe_q <= 1'h0;
			busy_q    <= 1'h0;
		end else begin
			dout_oe_q <= cs_s & (in_busy | rdy_q); // [R4] [R5] [R7] [R11]
			dout_q    <= in_busy ? `EWBS_ST_BUSY : rdy_q; // [R4] [R5]
			busy_q    <= in_busy;
		end
	end

	// Array write issued once, at the end of the self-timed cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			nv_wr_stb_q  <= 1'h0;
			nv_wr_addr_q <= '0;
			nv_wr_data_q <= '0;
		end else begin
			nv_wr_stb_q  <= wr_done; // [R1]
			nv_wr_addr_q <= cmd_q.addr;
			nv_wr_data_q <= cmd_q.data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_busy_sel;
		in_busy && cs_s && !wr_done;
	endsequence

	sequence s_ready_sel;
		!in_busy && rdy_q && cs_s;
	endsequence

	sequence s_write_end;
		wr_done ##1 nv_wr_stb_q;
	endsequence

	a_busy_drives_low: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R4]
		s_busy_sel |=> dout_oe_q && dout_q == `EWBS_ST_BUSY)
		else $error("busy status not low while selected");

	a_ready_drives_high: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R5]
		s_ready_sel |=> dout_oe_q && dout_q == `EWBS_ST_READY)
		else $error("ready status not high while selected");

	a_deselect_release: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R11]
		!cs_s |=> !dout_oe_q)
		else $error("data output driven while deselected");

	a_start_clears_ready: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R9]
		start_bit && !wr_done |=> !rdy_q ##1 !(dout_oe_q && dout_q))
		else $error("start bit did not clear ready");

	a_ready_holds: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R8]
		s_write_end |-> rdy_q ##1 (rdy_q || $past(start_bit)))
		else $error("ready lost without start bit");

	a_write_begins: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R2]
		arm_go |=> in_busy && wcnt_q == '0)
		else $error("write did not start on select low");

	a_busy_ignores_bus: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R1]
		in_busy && !wr_done && sk_rise |=> in_busy && $stable(cmd_q))
		else $error("array operation accepted while busy");

	a_partial_dropped: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R10]
		state_q == ewbs_pkg::EWBS_SHIFT && !cs_s |=> state_q == ewbs_pkg::EWBS_IDLE
		##1 !nv_wr_stb_q)
		else $error("partial command not discarded");

	a_status_no_clock: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R7]
		s_busy_sel ##1 (s_busy_sel and $stable(pins_s.serial_clock)) |=> dout_oe_q)
		else $error("status depends on serial clock");

endmodule

// ==== verilog/ewbs_defs.svh ====
`ifndef EWBS_DEFS_SVH
`define EWBS_DEFS_SVH

// Clock rate and self-timed write duration
`define EWBS_CLK_KHZ    250000
`define EWBS_T_WRITE_MS 10
`define EWBS_WRITE_CYC  (`EWBS_T_WRITE_MS * `EWBS_CLK_KHZ)
`define EWBS_WCNT_W     22

// Command frame after the start bit: opcode, address, data
`define EWBS_OP_W       2
`define EWBS_ADDR_W     7
`define EWBS_DATA_W     8
`define EWBS_CMD_BITS   (`EWBS_OP_W + `EWBS_ADDR_W + `EWBS_DATA_W)
`define EWBS_BCNT_W     5
`define EWBS_OP_WRITE   2'h1

// Status levels on the data output
`define EWBS_ST_BUSY    1'h0
`define EWBS_ST_READY   1'h1

`endif

// ==== verilog/ewbs_pkg.sv ====
`include "ewbs_defs.svh"

package ewbs_pkg;

	typedef enum logic [1:0] {
		EWBS_IDLE  = 2'b00,
		EWBS_SHIFT = 2'b01,
		EWBS_ARMED = 2'b10,
		EWBS_BUSY  = 2'b11
	} ewbs_state_e;

	typedef struct packed {
		logic [`EWBS_OP_W-1:0]   op;
		logic [`EWBS_ADDR_W-1:0] addr;
		logic [`EWBS_DATA_W-1:0] data;
	} ewbs_cmd_s;

	typedef struct packed {
		logic chip_sel;
		logic serial_clock;
		logic serial_data_in;
	} ewbs_pins_s;

endpackage

// ==== verilog/ewbs_sync.sv ====
`timescale 1ns/1ns

// Two-flop synchroniser for a group of pin inputs
module ewbs_sync #(
	parameter int W = 3
) (
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// ==== dv/ewbs_host.sv ====
`timescale 1ns/1ns

// Host side of the three-wire link; serial clock rests low outside frames
module ewbs_host (
	input  wire logic            clk_sys,
	output ewbs_pkg::ewbs_pins_s pins
);
	initial begin
		pins = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// Wait a number of clock cycles
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Select or release; data line is inverted when the device is released
	task automatic select(input logic v);
		pins.chip_sel <= v;
		if (!v) begin
			pins.serial_data_in <= ~pins.serial_data_in;
		end
		tick(4);
	endtask

	// One bit: clock low then high, each phase three cycles
	task automatic send_bit(input logic b);
		pins.serial_data_in <= b;
		tick(3);
		pins.serial_clock <= 1'h1;
		tick(3);
		pins.serial_clock <= 1'h0;
	endtask

	// Start bit, then the top n bits of val, most significant first
	task automatic send(input logic [16:0] val, input int n);
		send_bit(1'h1);
		for (int i = 16; i > 16 - n; i--) begin
			send_bit(val[i]);
		end
		tick(3);
	endtask
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
`include "ewbs_defs.svh"

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin miscompares++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module tb_top;
	localparam int WCYC = 200;
	logic                     clk_sys = 1'h0;
	logic                     sys_rst = 1'h1;
	ewbs_pkg::ewbs_pins_s     pins;
	logic                     dout_q;
	logic                     dout_oe_q;
	logic                     busy_q;
	logic                     nv_wr_stb_q;
	logic [`EWBS_ADDR_W-1:0]  nv_wr_addr_q;
	logic [`EWBS_DATA_W-1:0]  nv_wr_data_q;
	ewbs_pkg::ewbs_cmd_s      exp_q[$];
	ewbs_pkg::ewbs_cmd_s      cmd;
	ewbs_pkg::ewbs_cmd_s      e;
	int                       miscompares = 0;
	int                       checked = 0;
	int                       cycles = 0;

	// Free-running clock
	always #2 clk_sys = ~clk_sys;

	ewbs_host ewbs_host_inst (.clk_sys(clk_sys), .pins(pins));

	ewbs_top #(.WRITE_CYC(WCYC)) ewbs_top_inst (
		.clk_sys        (clk_sys),
		.sys_rst        (sys_rst),
		.chip_sel       (pins.chip_sel),
		.serial_clock   (pins.serial_clock),
		.serial_data_in (pins.serial_data_in),
		.dout_q         (dout_q),
		.dout_oe_q      (dout_oe_q),
		.busy_q         (busy_q),
		.nv_wr_stb_q    (nv_wr_stb_q),
		.nv_wr_addr_q   (nv_wr_addr_q),
		.nv_wr_data_q   (nv_wr_data_q)
	);

	////////////////////////////////////////////////////////////////////////
	// Print counts and verdict, then stop
	task automatic close_out();
		$display("counts: checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Sample the data output mid-cycle, then realign to the rising edge
	task automatic status(input string nm, input logic oe, input logic dv);
		@(negedge clk_sys);
		`CHK(nm, oe, dout_oe_q)
		if (oe) begin
			`CHK(nm, dv, dout_q)
		end
		@(posedge clk_sys);
	endtask

	// Wait a bounded time for the busy flag to reach a level; sample mid-cycle
	task automatic wait_busy(input logic v, input int lim);
		int n;
		n = 0;
		@(negedge clk_sys);
		while (busy_q !== v && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
		`CHK("busy level", v, busy_q)
		@(posedge clk_sys);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Watch array writes against the queue of notes; cut a hang short
	// Sampled mid-cycle so registered outputs have settled
	always @(negedge clk_sys) begin
		cycles++;
		if (nv_wr_stb_q === 1'h1) begin
			if (exp_q.size() == 0) begin
				`CHK("unexpected write", 1'h0, nv_wr_stb_q)
			end else begin
				e = exp_q.pop_front();
				`CHK("write addr", e.addr, nv_wr_addr_q)
				`CHK("write data", e.data, nv_wr_data_q)
			end
		end
		if (cycles > 20000) begin
			miscompares++;
			close_out();
		end
	end

	// Main sequence
	initial begin
		void'($urandom(17));
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'h0;
		status("released after reset", 1'h0, 1'h0);
		for (int k = 0; k < 2; k++) begin
			cmd = (`EWBS_CMD_BITS)'($urandom);
			cmd.op = `EWBS_OP_WRITE;
			ewbs_host_inst.select(1'h1);
			ewbs_host_inst.send(cmd, 17);
			exp_q.push_back(cmd);
			ewbs_host_inst.select(1'h0);
			wait_busy(1'h1, 10);
			ewbs_host_inst.select(1'h1);
			status("busy shown", 1'h1, `EWBS_ST_BUSY);
			if (k == 0) begin
				ewbs_host_inst.send(cmd ^ 17'h1, 17);
				ewbs_host_inst.select(1'h0);
				wait_busy(1'h0, WCYC);
			end else begin
				ewbs_host_inst.select(1'h0);
				repeat (WCYC) @(posedge clk_sys);
				`CHK("busy after fixed wait", 1'h0, busy_q)
			end
			ewbs_host_inst.select(1'h1);
			status("ready shown", 1'h1, `EWBS_ST_READY);
			repeat (20) @(posedge clk_sys);
			status("ready held", 1'h1, `EWBS_ST_READY);
			ewbs_host_inst.select(1'h0);
			status("released", 1'h0, 1'h0);
			ewbs_host_inst.select(1'h1);
			status("ready reselected", 1'h1, `EWBS_ST_READY);
			$display("write test %0d done", k);
		end
		ewbs_host_inst.send(17'h0, 0);
		status("ready cleared", 1'h0, 1'h0);
		ewbs_host_inst.select(1'h0);
		ewbs_host_inst.select(1'h1);
		status("cleared stays", 1'h0, 1'h0);
		ewbs_host_inst.send(cmd, 10);
		ewbs_host_inst.select(1'h0);
		repeat (20) @(posedge clk_sys);
		`CHK("partial frame busy", 1'h0, busy_q)
		// A complete frame with a non-write opcode must not start a write
		cmd.op = 2'h2;
		ewbs_host_inst.select(1'h1);
		ewbs_host_inst.send(cmd, 17);
		ewbs_host_inst.select(1'h0);
		repeat (20) @(posedge clk_sys);
		`CHK("non-write frame busy", 1'h0, busy_q)
		repeat (WCYC) @(posedge clk_sys);
		`CHK("writes pending", 0, exp_q.size())
		$display("clear and partial test done");
		close_out();
	end
endmodule
